// *** core/ssx_defines.vh ***
`ifndef SSX_DEFINES_VH
`define SSX_DEFINES_VH

// Register byte addresses on the AXI4-Lite bus
`define SSX_ADDR_DATA 9'h0F4
`define SSX_ADDR_CTRL 9'h0F8
`define SSX_ADDR_STAT 9'h0FC
`define SSX_ADDR_RXBUF 9'h100

// Control register field positions
`define SSX_CTRL_EN 7
`define SSX_CTRL_SEL_HI 5
`define SSX_CTRL_SEL_LO 3
`define SSX_CTRL_RSV 2
`define SSX_CTRL_OE 1

// Status register field positions
`define SSX_STAT_DONE 0
`define SSX_STAT_FULL 1
`define SSX_STAT_BUSY 2

// Reset values
`define SSX_RST_DATA 8'h00
`define SSX_RST_SEL 3'h0
`define SSX_RST_BYTE 8'h00

// Clock source select code for the external clock pin
`define SSX_SEL_EXT 3'h0

// Bits per transfer and system clock divider base ratio
`define SSX_BITS 4'h8
`define SSX_DIV_BASE 24

// AXI responses
`define SSX_RESP_OKAY 2'h0
`define SSX_RESP_SLVERR 2'h2

`endif

// *** core/ssx_sync.v ***
`timescale 1ns/1ps
// Two-stage synchroniser for pins coming from outside the mclk domain
module ssx_sync #(
	parameter WIDTH = 2
) (
	input wire mclk,
	input wire reset,
	input wire [WIDTH-1:0] asyncIn,
	output reg [WIDTH-1:0] syncOut
);
	reg [WIDTH-1:0] stage1;

	// First stage is read by the second stage only
	always @(posedge mclk) begin
		if (reset) begin
			stage1 <= {WIDTH{1'b1}};
			syncOut <= {WIDTH{1'b1}};
		end else begin
			stage1 <= asyncIn;
			syncOut <= stage1;
		end
	end
endmodule

// *** core/ssx_clk_div.v ***
`timescale 1ns/1ps
`include "ssx_defines.vh"
// Internal serial clock: mclk divided by 24 times a power of two
module ssx_clk_div (
	input wire mclk,
	input wire reset,
	input wire run,
	input wire [2:0] sel,
	output reg level,
	output reg risePulse,
	output reg fallPulse
);
	reg [9:0] halfCnt;

	// Half period in mclk cycles for each divided select code
	function [9:0] halfCount;
		input [2:0] s;
		begin
			case (s)
				3'h1: halfCount = 10'h00C;
				3'h2: halfCount = 10'h018;
				3'h3: halfCount = 10'h030;
				3'h4: halfCount = 10'h060;
				3'h5: halfCount = 10'h0C0;
				3'h6: halfCount = 10'h180;
				default: halfCount = 10'h300;
			endcase
		end
	endfunction

	// Idles high so the first edge of a transfer is a falling one
	always @(posedge mclk) begin
		if (reset || !run) begin
			halfCnt <= 10'h000;
			level <= 1'b1;
			risePulse <= 1'b0;
			fallPulse <= 1'b0;
		end else begin
			risePulse <= 1'b0;
			fallPulse <= 1'b0;
			if (halfCnt == halfCount(sel) - 10'h001) begin
				halfCnt <= 10'h000;
				level <= ~level;
				risePulse <= ~level;
				fallPulse <= level;
			end else begin
				halfCnt <= halfCnt + 10'h001;
			end
		end
	end
endmodule

// *** core/ssx_serial_top.v ***
// Functional notes
// - Three 8-bit modes: transmit only, receive only, and full duplex.
// - Received byte is buffered so a new reception may start before read.
// - Unread buffered byte is overwritten by the next; no protection.
// - Clock mux, up-counter, shift register, output flop, control, buffer.
// - Transmit and duplex modes need output enable bit 1 set.
// - With output enable clear, the serial out pin is released.
// - Nonzero select turns the clock pin into a driven output.
// - Transmit only leaves the serial in pin to ordinary port use.
// - Shift register bit 7 loads from the serial in pin.
// - Shift register advances once on each rising serial clock edge.
// - After eight shifts the data register holds the received byte.
// - While disabled the clock is held high and the counter at zero.
// - While enabled the clock runs; counter counts its falling edges.
// - Select 001 to 111 divide mclk by 24 up to 1536.
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`include "ssx_defines.vh"
module ssx_serial_top #(
	parameter ADDR_WIDTH = 9
) (
	input wire mclk,
	input wire reset,
	// AXI4-Lite slave
	input wire [ADDR_WIDTH-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [ADDR_WIDTH-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Serial pins
	input wire serialInPin,
	output reg serialOutPin,
	output reg serialOutEnable,
	input wire serialClockIn,
	output reg serialClockOut,
	output reg serialClockEnable,
	// Transfer complete request, a level until cleared
	output reg xferDoneReq
);
	// Control register fields
	reg serialUnitEnable;
	reg [2:0] clockSourceSelect;
	reg serialOutPinEnable;
	reg ctrlReserved;

	// Datapath state
	reg [7:0] shiftData;
	reg [7:0] rxBuffer;
	reg rxFull;
	reg doneFlag;
	reg [3:0] bitCount;
	reg outBit;

	// Bus bookkeeping
	reg [ADDR_WIDTH-1:0] awAddr;
	reg awHeld;
	reg [31:0] wData;
	reg [3:0] wStrb;
	reg wHeld;

	// Synchronised pins and clock edge detection
	wire [1:0] pinSync;
	wire siSync;
	wire sckSync;
	reg sckPrev;
	wire intLevel;
	wire intRise;
	wire intFall;
	wire extMode;
	wire serRise;
	wire serFall;
	wire [7:0] next_shift;
	wire lastShift;
	wire doWrite;
	wire doRead;
	wire readRxBuf;
	wire wrData;
	wire wrCtrl;
	wire wrStat;
	reg [31:0] next_rdata;
	reg [1:0] next_rresp;

	// Both pins come from outside the mclk domain
	ssx_sync #(
		.WIDTH(2)
	) u_sync (
		.mclk(mclk),
		.reset(reset),
		.asyncIn({serialInPin, serialClockIn}),
		.syncOut(pinSync)
	);

	// Data pin is only sampled here; its direction is left to port logic
	assign siSync = pinSync[1];
	assign sckSync = pinSync[0];

	// Divided system clock runs only while the unit is enabled
	ssx_clk_div u_div (
		.mclk(mclk),
		.reset(reset),
		.run(serialUnitEnable && !extMode),
		.sel(clockSourceSelect),
		.level(intLevel),
		.risePulse(intRise),
		.fallPulse(intFall)
	);

	// Clock source multiplexer
	assign extMode = (clockSourceSelect == `SSX_SEL_EXT);
	assign serRise = serialUnitEnable &&
		(extMode ? (sckSync && !sckPrev) : intRise);
	assign serFall = serialUnitEnable &&
		(extMode ? (!sckSync && sckPrev) : intFall);

	// Edge detector looks at the synchronised level only
	always @(posedge mclk) begin
		if (reset) begin
			sckPrev <= 1'b1;
		end else begin
			sckPrev <= sckSync;
		end
	end

	// New bit enters at the top and moves toward bit 0
	assign next_shift = {siSync, shiftData[7:1]};
	// A rise with no preceding fall is ignored, so the idle-high clock
	// cannot shift before the first bit has been presented on the pin
	assign lastShift = serRise && (bitCount == `SSX_BITS);

	// Bus write and read strobes
	assign doWrite = awHeld && wHeld && !s_axi_bvalid;
	assign doRead = s_axi_arvalid && s_axi_arready;
	assign readRxBuf = doRead && (s_axi_araddr == `SSX_ADDR_RXBUF);

	// Per-register write strobes; only byte lane 0 carries register bits
	assign wrData = doWrite && (awAddr == `SSX_ADDR_DATA) && wStrb[0];
	assign wrCtrl = doWrite && (awAddr == `SSX_ADDR_CTRL) && wStrb[0];
	assign wrStat = doWrite && (awAddr == `SSX_ADDR_STAT) && wStrb[0];

	// Registers that accept a write; the receive buffer is read only,
	// so a write to it is answered with an error and changes nothing
	function isWritable;
		input [ADDR_WIDTH-1:0] a;
		begin
			isWritable = (a == `SSX_ADDR_DATA) ||
				(a == `SSX_ADDR_CTRL) || (a == `SSX_ADDR_STAT);
		end
	endfunction

	// Write address and data channels are taken in either order
	always @(posedge mclk) begin
		if (reset) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SSX_RESP_OKAY;
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awAddr <= {ADDR_WIDTH{1'b0}};
			wData <= 32'h00000000;
			wStrb <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awAddr <= s_axi_awaddr;
				awHeld <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wData <= s_axi_wdata;
				wStrb <= s_axi_wstrb;
				wHeld <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (doWrite) begin
				awHeld <= 1'b0;
				wHeld <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (isWritable(awAddr)) begin
					s_axi_bresp <= `SSX_RESP_OKAY;
				end else begin
					s_axi_bresp <= `SSX_RESP_SLVERR;
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Read data decode
	always @* begin
		next_rdata = 32'h00000000;
		next_rresp = `SSX_RESP_OKAY;
		if (s_axi_araddr == `SSX_ADDR_DATA) begin
			next_rdata[7:0] = shiftData;
		end else if (s_axi_araddr == `SSX_ADDR_CTRL) begin
			next_rdata[`SSX_CTRL_EN] = serialUnitEnable;
			next_rdata[`SSX_CTRL_SEL_HI:`SSX_CTRL_SEL_LO] = clockSourceSelect;
			next_rdata[`SSX_CTRL_RSV] = ctrlReserved;
			next_rdata[`SSX_CTRL_OE] = serialOutPinEnable;
		end else if (s_axi_araddr == `SSX_ADDR_STAT) begin
			next_rdata[`SSX_STAT_DONE] = doneFlag;
			next_rdata[`SSX_STAT_FULL] = rxFull;
			next_rdata[`SSX_STAT_BUSY] = serialUnitEnable;
		end else if (s_axi_araddr == `SSX_ADDR_RXBUF) begin
			next_rdata[7:0] = rxBuffer;
		end else begin
			next_rresp = `SSX_RESP_SLVERR;
		end
	end

	// One read in flight; address accepted, data one cycle later
	always @(posedge mclk) begin
		if (reset) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `SSX_RESP_OKAY;
		end else begin
			if (doRead) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= next_rdata;
				s_axi_rresp <= next_rresp;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// Control register; completion clears the enable bit
	always @(posedge mclk) begin
		if (reset) begin
			serialUnitEnable <= 1'b0;
			clockSourceSelect <= `SSX_RST_SEL;
			serialOutPinEnable <= 1'b0;
			ctrlReserved <= 1'b0;
		end else if (wrCtrl) begin
			// A software write in the completion cycle takes priority over the enable clear
			serialUnitEnable <= wData[`SSX_CTRL_EN];
			clockSourceSelect <= wData[`SSX_CTRL_SEL_HI:`SSX_CTRL_SEL_LO];
			serialOutPinEnable <= wData[`SSX_CTRL_OE];
			ctrlReserved <= wData[`SSX_CTRL_RSV];
		end else if (lastShift) begin
			serialUnitEnable <= 1'b0;
		end
	end

	// Bit counter counts falling edges, cleared while disabled
	always @(posedge mclk) begin
		if (reset || !serialUnitEnable) begin
			bitCount <= 4'h0;
		end else if (serFall && bitCount != `SSX_BITS) begin
			bitCount <= bitCount + 4'h1;
		end
	end

	// Shift register: software load, or shift on each rising edge.
	// Shifting goes on in every mode so receive data always lands here.
	always @(posedge mclk) begin
		if (reset) begin
			shiftData <= `SSX_RST_DATA;
		end else if (wrData) begin
			shiftData <= wData[7:0];
		end else if (serRise && bitCount != 4'h0) begin
			shiftData <= next_shift;
		end
	end

	// Output flop takes bit 0 on each falling edge
	always @(posedge mclk) begin
		if (reset) begin
			outBit <= 1'b1;
		end else if (serFall && bitCount != `SSX_BITS) begin
			outBit <= shiftData[0];
		end
	end

	// Receive buffer; a late read simply loses the older byte
	always @(posedge mclk) begin
		if (reset) begin
			rxBuffer <= `SSX_RST_BYTE;
			rxFull <= 1'b0;
		end else if (lastShift) begin
			rxBuffer <= next_shift;
			rxFull <= 1'b1; // Set wins over a read in the same cycle
		end else if (readRxBuf) begin
			rxFull <= 1'b0;
		end
	end

	// Completion flag, write one to clear; a new completion wins
	always @(posedge mclk) begin
		if (reset) begin
			doneFlag <= 1'b0;
		end else if (lastShift) begin
			doneFlag <= 1'b1;
		end else if (wrStat && wData[`SSX_STAT_DONE]) begin
			doneFlag <= 1'b0;
		end
	end

	// Pin drivers, each from a flop.
	// The clock pin enable follows the select alone, so the pin is an
	// output even while idle; it then rests at its idle-high level.
	always @(posedge mclk) begin
		if (reset) begin
			serialOutPin <= 1'b1;
			serialOutEnable <= 1'b0;
			serialClockOut <= 1'b1;
			serialClockEnable <= 1'b0;
			xferDoneReq <= 1'b0;
		end else begin
			serialOutPin <= outBit;
			serialOutEnable <= serialOutPinEnable;
			// Held high unless the divided clock is running
			serialClockOut <= extMode ? 1'b1 : intLevel;
			serialClockEnable <= !extMode;
			xferDoneReq <= doneFlag;
		end
	end
endmodule

// *** bench/ssx_props.sv ***
`timescale 1ns/1ps
// Pin and bus timing seen at the block's ports
module ssx_props (
	input wire mclk,
	input wire reset,
	input wire s_axi_awready,
	input wire s_axi_bvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire serialOutPin,
	input wire serialOutEnable,
	input wire serialClockOut,
	input wire serialClockEnable,
	input wire xferDoneReq
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	// Leaving reset, clock and data pins idle high
	property p_idle;
		$fell(reset) |-> serialClockOut && serialOutPin && !xferDoneReq;
	endproperty
	a_idle: assert property (p_idle) else $error("pins not idle");
	// Fastest divider holds each half for 12 cycles
	property p_lowMin;
		$fell(serialClockOut) |-> !serialClockOut [*8];
	endproperty
	a_lowMin: assert property (p_lowMin) else $error("low short");
	property p_highMin;
		$rose(serialClockOut) |-> serialClockOut [*8];
	endproperty
	a_highMin: assert property (p_highMin) else $error("high short");
	// Only a selected internal clock may toggle the pin
	property p_fallSel;
		$fell(serialClockOut) |-> serialClockEnable;
	endproperty
	a_fallSel: assert property (p_fallSel) else $error("pin not out");
	// Data leaves while the clock is low, never under a high clock
	property p_outFall;
		$changed(serialOutPin) && serialClockEnable |-> !serialClockOut;
	endproperty
	a_outFall: assert property (p_outFall) else $error("data moved");
	// A finished byte leaves the clock parked high
	property p_doneStop;
		$rose(xferDoneReq) |-> serialClockOut [*8];
	endproperty
	a_doneStop: assert property (p_doneStop) else $error("clock ran");
	property p_bAw;
		$rose(s_axi_bvalid) |-> !s_axi_awready;
	endproperty
	a_bAw: assert property (p_bAw) else $error("awready during b");
	property p_rAr;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_rAr: assert property (p_rAr) else $error("arready during r");
endmodule

// *** bench/ssx_peer.sv ***
`timescale 1ns/1ps
// Far-side serial chip: LSB-first talker and listener
module ssx_peer (
	input wire mclk,
	input wire start,
	input wire ext,
	input wire clkOut,
	input wire clkOe,
	input wire dOut,
	input wire [7:0] txByte,
	output reg extClk,
	output reg dIn,
	output reg [7:0] rxByte
);
	wire sck = clkOe ? clkOut : extClk;
	int k = 8;
	initial begin
		extClk = 1;
		dIn = 0;
		rxByte = 0;
	end
	// New frame; in external mode we make 8 clocks, idle high
	always @(posedge start) begin
		k = 0;
		if (ext)
			repeat (16) begin
				repeat (8) @(posedge mclk);
				extClk <= ~extClk;
			end
	end
	// Change on the fall so data is settled at the rise
	always @(negedge sck)
		if (k < 8) begin
			dIn <= txByte[k];
			k = k + 1;
		end
	// Capture on the rise; after the hold the line is inverted
	always @(posedge sck) begin
		rxByte <= {dOut, rxByte[7:1]};
		if (k == 8) begin
			repeat (4) @(posedge mclk);
			dIn <= ~dIn;
		end
	end
endmodule

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
`include "ssx_defines.vh"
module tb_top;
	logic mclk = 0, reset = 1, start = 0, ext = 0;
	logic awv = 0, wv = 0, bRdy = 0, arv = 0, rRdy = 0;
	logic [8:0] awa = 0, ara = 0;
	logic [31:0] wd = 0, rdat;
	logic awr, wr, bv, arr, rv, sOut, sOe, cOut, cOe, done, sIn, xClk;
	logic [1:0] br, rr;
	logic [7:0] txB = 0, rxB;
	int mismatches = 0, checked = 0;
	always #10 mclk = ~mclk;
	ssx_serial_top i_dut (.mclk(mclk), .reset(reset),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
		.s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
		.s_axi_bready(bRdy), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
		.s_axi_rvalid(rv), .s_axi_rready(rRdy), .serialInPin(sIn),
		.serialOutPin(sOut), .serialOutEnable(sOe), .serialClockIn(xClk),
		.serialClockOut(cOut), .serialClockEnable(cOe),
		.xferDoneReq(done));
	ssx_peer i_peer (.mclk(mclk), .start(start), .ext(ext), .clkOut(cOut),
		.clkOe(cOe), .dOut(sOut), .txByte(txB), .extClk(xClk), .dIn(sIn),
		.rxByte(rxB));
	task chk(string n, logic [31:0] s, logic [31:0] e);
		checked++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch %s exp %h got %h", n, e, s);
		end
	endtask
	task finish_test();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task tmo(int i, int n);
		if (i >= n) begin
			chk("timeout", 1, 0);
			finish_test();
		end
	endtask
	// Each channel is dropped at its own handshake edge
	task wrr(logic [8:0] a, logic [7:0] d, logic [1:0] e);
		int i;
		awa <= a;
		wd <= {24'h0, d};
		awv <= 1;
		wv <= 1;
		bRdy <= 1;
		i = 0;
		do begin
			@(posedge mclk);
			if (awr) awv <= 0;
			if (wr) wv <= 0;
			i++;
		end while (!bv && i < 50);
		tmo(i, 50);
		// bready stays high so a following call never re-raises it
		chk($sformatf("bresp %h", a), br, e);
	endtask
	task rd(logic [8:0] a, logic [7:0] d, logic [1:0] e);
		int i;
		ara <= a;
		arv <= 1;
		rRdy <= 1;
		i = 0;
		do begin
			@(posedge mclk);
			if (arr) arv <= 0;
			i++;
		end while (!rv && i < 50);
		tmo(i, 50);
		// rready stays high so a following call never re-raises it
		chk($sformatf("rresp %h", a), rr, e);
		if (e == 0)
			chk($sformatf("reg %h", a), rdat, {24'h0, d});
	endtask
	task pulse();
		start <= 1;
		@(posedge mclk);
		start <= 0;
	endtask
	task waitDone();
		int i;
		for (i = 0; i < 20000 && done !== 1; i++)
			@(posedge mclk);
		tmo(i, 20000);
	endtask
	task tReset();
		rd(`SSX_ADDR_CTRL, 8'h00, 0);
		rd(`SSX_ADDR_STAT, 8'h00, 0);
		rd(`SSX_ADDR_DATA, 8'h00, 0);
		rd(9'h040, 8'h00, 2);
		wrr(`SSX_ADDR_RXBUF, 8'h11, 2);
		chk("clkPin", cOut, 1);
		$display("reset test done");
	endtask
	// Internal /24, both directions at once
	task tDuplex();
		txB <= 8'hA5;
		pulse();
		wrr(`SSX_ADDR_DATA, 8'h3C, 0);
		wrr(`SSX_ADDR_CTRL, 8'h8A, 0);
		// Pin flops follow the control register one cycle after the write
		repeat (2) @(posedge mclk);
		chk("oe", sOe, 1);
		chk("clkOe", cOe, 1);
		waitDone();
		rd(`SSX_ADDR_DATA, 8'hA5, 0);
		rd(`SSX_ADDR_CTRL, 8'h0A, 0);
		rd(`SSX_ADDR_STAT, 8'h03, 0);
		chk("peerRx", rxB, 8'h3C);
		wrr(`SSX_ADDR_STAT, 8'h01, 0);
		$display("duplex test done");
	endtask
	// External clock, receive only, over an unread byte
	task tRecv();
		txB <= 8'h5A;
		ext <= 1;
		wrr(`SSX_ADDR_CTRL, 8'h80, 0);
		repeat (2) @(posedge mclk);
		chk("oe", sOe, 0);
		chk("clkOe", cOe, 0);
		pulse();
		waitDone();
		rd(`SSX_ADDR_RXBUF, 8'h5A, 0);
		rd(`SSX_ADDR_DATA, 8'h5A, 0);
		rd(`SSX_ADDR_STAT, 8'h01, 0);
		wrr(`SSX_ADDR_STAT, 8'h01, 0);
		ext <= 0;
		$display("receive test done");
	endtask
	// Both directions through every divider, timing the low half
	task tDiv();
		int s, i, n;
		for (s = 1; s < 8; s++) begin
			txB <= {s[3:0], ~s[3:0]};
			pulse();
			wrr(`SSX_ADDR_DATA, {~s[3:0], s[3:0]}, 0);
			wrr(`SSX_ADDR_CTRL, {2'b10, s[2:0], 3'b010}, 0);
			for (i = 0; i < 2000 && cOut !== 0; i++)
				@(posedge mclk);
			tmo(i, 2000);
			for (n = 0; n < 2000 && cOut === 0; n++)
				@(posedge mclk);
			chk("halfLow", n, 12 << (s - 1));
			waitDone();
			chk("peerRx", rxB, {~s[3:0], s[3:0]});
			rd(`SSX_ADDR_DATA, {s[3:0], ~s[3:0]}, 0);
			wrr(`SSX_ADDR_STAT, 8'h01, 0);
		end
		$display("divider test done");
	endtask
	initial begin
		repeat (10) @(posedge mclk);
		reset <= 0;
		tReset();
		tDuplex();
		tRecv();
		tDiv();
		finish_test();
	end
endmodule
bind ssx_serial_top ssx_props i_props (.mclk(mclk), .reset(reset),
	.s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.serialOutPin(serialOutPin), .serialOutEnable(serialOutEnable),
	.serialClockOut(serialClockOut), .serialClockEnable(serialClockEnable),
	.xferDoneReq(xferDoneReq));
